// ### spkctl_ctl.sv
// Controller end: APB slave that shifts and latches control words
`timescale 1ns/1ps
`default_nettype none
module spkctl_ctl
  import spkctl_pkg::*;
#(
  parameter int HALF_CYC = SPKCTL_LINK_HALF
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Link
  spkctl_if.ctl            link
);
  typedef enum logic [2:0] {SC_IDLE, SC_LOW, SC_HIGH, SC_STRB, SC_DONE} spkctl_st_t;

  spkctl_st_t st;
  logic [7:0]  word;
  logic [7:0]  last_word;
  logic [2:0]  bit_idx;
  logic [7:0]  cnt;
  logic        pd;
  logic        rreset_n;
  logic        sclk;
  logic        sdat;
  logic        strb;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire acc      = psel_i & penable_i;
  wire busy     = (st != SC_IDLE);
  wire wr_word  = acc & pwrite_i & (paddr_i == SPKCTL_REG_WORD) & ~busy;
  wire wr_ctrl  = acc & pwrite_i & (paddr_i == SPKCTL_REG_CTRL);
  wire known    = (paddr_i == SPKCTL_REG_WORD) | (paddr_i == SPKCTL_REG_CTRL) | (paddr_i == SPKCTL_REG_STATUS);
  wire cnt_done = (cnt == 8'(HALF_CYC - 1));
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & (~known | (pwrite_i & (paddr_i == SPKCTL_REG_WORD) & busy));
  wire [31:0] rd_mux = (paddr_i == SPKCTL_REG_WORD)   ? {24'h000000, last_word} :
                       (paddr_i == SPKCTL_REG_CTRL)   ? {30'h0, ~rreset_n, pd} :
                       (paddr_i == SPKCTL_REG_STATUS) ? {31'h0, busy} : 32'h00000000;
  wire        rd_setup = psel_i & ~penable_i & ~pwrite_i;

  assign link.ser_clk               = sclk;
  assign link.ser_data              = sdat;
  assign link.latch_strobe          = strb;
  assign link.chip_power_down_input = pd;
  assign link.reg_reset_n           = rreset_n;

  // ---------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_o <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pd       <= 1'b0;
      rreset_n <= 1'b1;
    end else if (wr_ctrl) begin
      pd       <= pwdata_i[SPKCTL_CTRL_PD_BIT];
      rreset_n <= ~pwdata_i[SPKCTL_CTRL_RST_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Link sequencer, divided clock at most 1 MHz
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st        <= SC_IDLE;
      word      <= 8'h00;
      last_word <= 8'h00;
      bit_idx   <= 3'h0;
      cnt       <= 8'h00;
      sclk      <= 1'b0;
      sdat      <= 1'b0;
      strb      <= 1'b0;
    end else begin
      cnt <= (busy && !cnt_done) ? cnt + 8'h01 : 8'h00;
      case (st)
        SC_IDLE: begin
          if (wr_word) begin
            word      <= pwdata_i[7:0];
            last_word <= pwdata_i[7:0];
            bit_idx   <= 3'h7;
            sdat      <= pwdata_i[7];
            st        <= SC_LOW;
          end
        end
        SC_LOW: begin
          if (cnt_done) begin
            sclk <= 1'b1;
            st   <= SC_HIGH;
          end
        end
        SC_HIGH: begin
          if (cnt_done) begin
            sclk <= 1'b0;
            strb <= 1'b0;
            if (bit_idx == 3'h0) begin
              st <= SC_STRB;
            end else begin
              bit_idx <= bit_idx - 3'h1;
              sdat    <= word[bit_idx - 3'h1];
              st      <= SC_LOW;
            end
          end
        end
        SC_STRB: begin
          if (cnt_done) begin
            strb <= 1'b1;
            st   <= SC_DONE;
          end
        end
        SC_DONE: begin
          if (cnt_done) begin
            strb <= 1'b0;
            st   <= SC_IDLE;
          end
        end
        default: begin
          st <= SC_IDLE;
        end
      endcase
    end
  end
endmodule : spkctl_ctl
`default_nettype wire

// ### spkctl_if.sv
// Interface joining the speakerphone control port device and its controller
`timescale 1ns/1ps
`default_nettype none
interface spkctl_if;
  logic ser_clk;
  logic ser_data;
  logic latch_strobe;
  logic chip_power_down_input;
  logic reg_reset_n;

  modport dev (
    input ser_clk,
    input ser_data,
    input latch_strobe,
    input chip_power_down_input,
    input reg_reset_n
  );

  modport ctl (
    output ser_clk,
    output ser_data,
    output latch_strobe,
    output chip_power_down_input,
    output reg_reset_n
  );
endinterface : spkctl_if
`default_nettype wire

// ### spkctl_pkg.sv
// Package of constants for the speakerphone serial control port
package spkctl_pkg;
  localparam int          SPKCTL_WORD_BITS   = 8;
  localparam int          SPKCTL_MODE_MSB    = 7;
  localparam int          SPKCTL_MODE_LSB    = 6;
  localparam int          SPKCTL_RANGE_BIT   = 5;
  localparam int          SPKCTL_MUTE_BIT    = 4;
  localparam int          SPKCTL_VOL_MSB     = 3;
  localparam int          SPKCTL_VOL_LSB     = 0;
  localparam logic [7:0]  SPKCTL_CTRL_RESET  = 8'h00;
  localparam logic [1:0]  SPKCTL_MODE_NORMAL = 2'h0;
  localparam logic [1:0]  SPKCTL_MODE_RX     = 2'h1;
  localparam logic [1:0]  SPKCTL_MODE_IDLE   = 2'h2;
  localparam logic [1:0]  SPKCTL_MODE_TX     = 2'h3;
  // Link clock timing
  localparam int          SPKCTL_SYS_MHZ     = 200;
  localparam int          SPKCTL_LINK_MAX_KHZ = 1000;
  localparam int          SPKCTL_LINK_HALF   = (SPKCTL_SYS_MHZ * 1000 + 2 * SPKCTL_LINK_MAX_KHZ - 1)
                                               / (2 * SPKCTL_LINK_MAX_KHZ);
  // APB register map of the controller
  localparam logic [7:0]  SPKCTL_REG_WORD    = 8'h00;
  localparam logic [7:0]  SPKCTL_REG_CTRL    = 8'h04;
  localparam logic [7:0]  SPKCTL_REG_STATUS  = 8'h08;
  localparam int          SPKCTL_CTRL_PD_BIT = 0;
  localparam int          SPKCTL_CTRL_RST_BIT = 1;
endpackage : spkctl_pkg

// ### spkctl_dev.sv
// Device end: serial shift register and control registers
//
// Function
// - Sample data on each rising link clock
// - Eight bit word, most significant bit first
// - Rising strobe copies word into control registers
// - Power-up and power-down clear control registers
// - Register reset low forces registers zero
// - Power-down high disables device, low active
// - Controller link rate at most 1 MHz
// - Extra clocks allowed only before strobe rises
// - Strobe low before first falling edge
// - Top two bits select switching mode
// - Bit five selects attenuator range
// - Bit four mutes microphone amplifier
// - Low four bits set receive volume
`timescale 1ns/1ps
`default_nettype none
module spkctl_dev
  import spkctl_pkg::*;
#(
  parameter int WORD_BITS = SPKCTL_WORD_BITS
) (
  // Power-on reset and link
  input  wire logic       rst_n_i,
  spkctl_if.dev           link,
  // Control outputs
  output logic [1:0]      mode_select_field_o,
  output logic            attenuator_range_bit_o,
  output logic            mic_mute_bit_o,
  output logic [3:0]      volume_code_field_o,
  output logic            device_active_o
);
  // ---------------------------------------------------------------
  // Clear conditions
  // ---------------------------------------------------------------
  wire clr_n = rst_n_i & link.reg_reset_n & ~link.chip_power_down_input;

  logic [WORD_BITS-1:0] shift_reg;
  logic [WORD_BITS-1:0] ctrl_reg;

  // ---------------------------------------------------------------
  // Input shift register
  // ---------------------------------------------------------------
  always_ff @(posedge link.ser_clk or negedge clr_n) begin
    if (!clr_n) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], link.ser_data};
    end
  end

  // ---------------------------------------------------------------
  // Control registers, loaded on strobe rise
  // ---------------------------------------------------------------
  always_ff @(posedge link.latch_strobe or negedge clr_n) begin
    if (!clr_n) begin
      ctrl_reg <= WORD_BITS'(SPKCTL_CTRL_RESET);
    end else begin
      ctrl_reg <= shift_reg;
    end
  end

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  assign mode_select_field_o    = ctrl_reg[SPKCTL_MODE_MSB:SPKCTL_MODE_LSB];
  assign attenuator_range_bit_o = ctrl_reg[SPKCTL_RANGE_BIT];
  assign mic_mute_bit_o         = ctrl_reg[SPKCTL_MUTE_BIT];
  assign volume_code_field_o    = ctrl_reg[SPKCTL_VOL_MSB:SPKCTL_VOL_LSB];
  assign device_active_o        = ~link.chip_power_down_input;
endmodule : spkctl_dev
`default_nettype wire

// ### spkctl_properties.sv
// Concurrent checks on the link between the two control port ends
`timescale 1ns/1ps
`default_nettype none
module spkctl_properties #(parameter int HALF_CYC = 100) (
  // Clock, reset and link
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       ser_clk,
  input wire logic       ser_data,
  input wire logic       latch_strobe,
  input wire logic       chip_power_down_input,
  input wire logic       reg_reset_n,
  // Device outputs
  input wire logic [1:0] mode_select_field_o,
  input wire logic       attenuator_range_bit_o,
  input wire logic       mic_mute_bit_o,
  input wire logic [3:0] volume_code_field_o,
  input wire logic       device_active_o
);
  logic       clk_q;
  logic [7:0] half;
  logic [3:0] nb;
  logic [7:0] sh;
  wire        rise = ser_clk & ~clk_q;
  wire  [7:0] word = {mode_select_field_o, attenuator_range_bit_o, mic_mute_bit_o, volume_code_field_o};
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_q <= 1'b0;
      half <= 8'hff;
      nb <= 4'h0;
      sh <= 8'h00;
    end else begin
      clk_q <= ser_clk;
      half <= (ser_clk != clk_q) ? 8'h01 : half + {7'h0, half != 8'hff};
      nb <= latch_strobe ? 4'h0 : nb + {3'h0, rise};
      sh <= rise ? {sh[6:0], ser_data} : sh;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RATE: assert property ((ser_clk != clk_q) |-> half >= HALF_CYC) else $error("link clock too fast");
  AST_SETUP: assert property (rise |-> $stable(ser_data)) else $error("data moved at clock rise");
  AST_NO_STB: assert property (rise |-> !latch_strobe) else $error("strobe high at clock rise");
  AST_STB_CLK: assert property (latch_strobe |-> !ser_clk) else $error("clock high during strobe");
  AST_EIGHT: assert property ($rose(latch_strobe) |-> nb == 4'h8) else $error("word not eight bits");
  AST_LATCH: assert property ($rose(latch_strobe) && reg_reset_n && !chip_power_down_input |-> word == sh)
    else $error("latched word differs");
  AST_HOLD: assert property ($changed(word) |-> $rose(latch_strobe) || !reg_reset_n || chip_power_down_input)
    else $error("outputs changed without latch");
  AST_RST_CLR: assert property (!reg_reset_n |-> word == 8'h00) else $error("reset did not clear");
  AST_PD_CLR: assert property (chip_power_down_input |-> word == 8'h00 && !device_active_o)
    else $error("power down did not clear");
  AST_ACTIVE: assert property (!chip_power_down_input |-> device_active_o) else $error("device not active");
  cover property ($rose(latch_strobe));
  cover property ($fell(reg_reset_n));
  cover property ($fell(chip_power_down_input));
endmodule : spkctl_properties
`default_nettype wire

// ### testbench.sv
// Testbench driving the controller over APB and watching the device outputs
`timescale 1ns/1ps
`default_nettype none
module testbench
  import spkctl_pkg::*;
;
  logic sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [1:0] mode_select_field_o;
  logic attenuator_range_bit_o, mic_mute_bit_o, device_active_o;
  logic [3:0] volume_code_field_o;
  int n_errors, checks;
  logic [7:0] wl[4] = '{8'h1f, 8'h60, 8'hb5, 8'hca};
  logic [1:0] ml[4] = '{SPKCTL_MODE_NORMAL, SPKCTL_MODE_RX, SPKCTL_MODE_IDLE, SPKCTL_MODE_TX};
  wire [8:0] st = {device_active_o, mode_select_field_o, attenuator_range_bit_o, mic_mute_bit_o, volume_code_field_o};
  spkctl_if link_if ();
  spkctl_ctl i_spkctl_ctl (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .link(link_if.ctl));
  spkctl_dev i_spkctl_dev (.rst_n_i, .link(link_if.dev), .mode_select_field_o, .attenuator_range_bit_o,
    .mic_mute_bit_o, .volume_code_field_o, .device_active_o);
  spkctl_properties #(.HALF_CYC(SPKCTL_LINK_HALF)) i_spkctl_properties (.sys_clk_i, .rst_n_i,
    .ser_clk(link_if.ser_clk), .ser_data(link_if.ser_data), .latch_strobe(link_if.latch_strobe),
    .reg_reset_n(link_if.reg_reset_n),
    .chip_power_down_input(link_if.chip_power_down_input), .mode_select_field_o, .attenuator_range_bit_o,
    .mic_mute_bit_o, .volume_code_field_o, .device_active_o);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wait_idle;
    rd = 32'h1;
    for (int i = 0; i < 2000 && rd[0] !== 1'b0; i++) apb(1'b0, SPKCTL_REG_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
  endtask : wait_idle
  task automatic send(input logic [7:0] w);
    apb(1'b1, SPKCTL_REG_WORD, {24'h0, w});
    wait_idle();
  endtask : send
  task automatic complete_run;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_errors++;
    complete_run();
  end
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    n_errors = 0;
    checks = 0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk({23'h0, st}, 32'h100);
    $display("test reset done");
    foreach (wl[i]) begin
      send(wl[i]);
      chk({23'h0, st}, {24'h1, wl[i]});
      chk({30'h0, mode_select_field_o}, {30'h0, ml[i]});
    end
    $display("test modes done");
    apb(1'b1, SPKCTL_REG_WORD, 32'h3c);
    repeat (800) @(posedge sys_clk_i);
    chk({24'h0, st[7:0]}, 32'hca);
    apb(1'b1, SPKCTL_REG_WORD, 32'h55);
    chk({31'h0, er}, 32'h1);
    wait_idle();
    chk({24'h0, st[7:0]}, 32'h3c);
    apb(1'b0, 8'h0c, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    $display("test shift done");
    apb(1'b1, SPKCTL_REG_CTRL, 32'h2);
    apb(1'b0, SPKCTL_REG_CTRL, 32'h0);
    chk(rd, 32'h2);
    repeat (3) @(posedge sys_clk_i);
    chk({23'h0, st}, 32'h100);
    apb(1'b1, SPKCTL_REG_CTRL, 32'h1);
    repeat (3) @(posedge sys_clk_i);
    chk({23'h0, st}, 32'h0);
    apb(1'b1, SPKCTL_REG_CTRL, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    chk({23'h0, st}, 32'h100);
    send(8'h81);
    chk({23'h0, st}, 32'h181);
    apb(1'b0, SPKCTL_REG_WORD, 32'h0);
    chk(rd, 32'h81);
    $display("test clear done");
    rst_n_i <= 1'b0;
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk({23'h0, st}, 32'h100);
    $display("test second reset done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
